// ==== design/ecm_memory_block.sv ====
// ecm_memory_block: embedded memory block with dual-clock and search (cam) modes
// assumes: write and read clocks are slow pins sampled by core_clk; apb master in core domain
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ecm_memory_block (
  // clock and chip reset
  input wire logic core_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // write side, from user logic
  input wire logic wrClk,
  input wire logic wrClr,
  input wire logic wrStrobe,
  input wire logic [4:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [31:0] wrMask,
  input wire logic wrMaskEn,
  // read side, from user logic
  input wire logic rdClk,
  input wire logic rdClr,
  input wire logic read_strobe,
  input wire logic [4:0] rdAddr,
  input wire logic [31:0] searchKey,
  // results
  output logic [31:0] rdData,
  output logic matchFound,
  output logic [4:0] matchAddr,
  output logic [15:0] matchLines,
  output logic matchUpper,
  output logic writeBusy
);

  // lowest matching index; ambiguous when nothing matches, since that also gives index 0
  // scanning downwards lets the lowest set flag be the last one taken
  function automatic logic [4:0] firstMatch(input logic [31:0] vec);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = ecm_pkg::DEPTH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 5'(i);
      end
    end
    firstMatch = idx;
  endfunction : firstMatch

  // two-flop synchronisers; stage one feeds stage two only
  // every pin is a level from another domain, so the third clock stage
  // only serves the edge detector and never feeds data logic
  logic wrClkS1, wrClkS2, wrClkS3;
  logic rdClkS1, rdClkS2, rdClkS3;
  logic wrClrS1, wrClrS2, rdClrS1, rdClrS2;
  ecm_pkg::ecm_wr_req_type wrReqS1, wrReqS2, wrQ;
  ecm_pkg::ecm_rd_req_type rdReqS1, rdReqS2;
  ecm_pkg::ecm_wr_req_type wrPin;
  ecm_pkg::ecm_rd_req_type rdPin;

  // pin bundles; request and clock share one latency, so data is settled at the tick
  assign wrPin = '{strobe: wrStrobe,
                   addr: wrAddr,
                   data: wrData,
                   mask: wrMask,
                   maskEn: wrMaskEn};
  assign rdPin = '{strobe: read_strobe,
                   addr: rdAddr,
                   key: searchKey};

  // write-side pin synchronisers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrClkS1 <= 1'b0;
      wrClkS2 <= 1'b0;
      wrClkS3 <= 1'b0;
      wrClrS1 <= 1'b0;
      wrClrS2 <= 1'b0;
      wrReqS1 <= '0;
      wrReqS2 <= '0;
    end else begin
      wrClkS1 <= wrClk;
      wrClkS2 <= wrClkS1;
      wrClkS3 <= wrClkS2;
      wrClrS1 <= wrClr;
      wrClrS2 <= wrClrS1;
      wrReqS1 <= wrPin;
      wrReqS2 <= wrReqS1;
    end
  end

  // read-side pin synchronisers, kept apart from the write side
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdClkS1 <= 1'b0;
      rdClkS2 <= 1'b0;
      rdClkS3 <= 1'b0;
      rdClrS1 <= 1'b0;
      rdClrS2 <= 1'b0;
      rdReqS1 <= '0;
      rdReqS2 <= '0;
    end else begin
      rdClkS1 <= rdClk;
      rdClkS2 <= rdClkS1;
      rdClkS3 <= rdClkS2;
      rdClrS1 <= rdClr;
      rdClrS2 <= rdClrS1;
      rdReqS1 <= rdPin;
      rdReqS2 <= rdReqS1;
    end
  end

  // apb control register
  logic [ecm_pkg::CTRL_BITS-1:0] ctrl;
  logic globalClr;
  wire apbAccess = psel && penable && !pready;
  // a write lands at the edge where the master sees pready high, not one edge earlier
  wire apbDone = psel && penable && pready;
  wire selCtrl = paddr == ecm_pkg::OFS_CTRL;
  wire selStatus = paddr == ecm_pkg::OFS_STATUS;
  wire selMatch = paddr == ecm_pkg::OFS_MATCH;
  wire apbHit = selCtrl || selStatus || selMatch;
  wire ctrlWrite = apbDone && pwrite && selCtrl;
  wire camMode = ctrl[ecm_pkg::CTRL_CAM];
  wire encMode = ctrl[ecm_pkg::CTRL_ENC];

  // side controls: each side sees its own enable and clear, plus the shared global clear
  // a disabled side ignores its clock pin, so a paused read side keeps its result
  // while writes continue, and the other way round
  wire wrTick = wrClkS2 && !wrClkS3 && ctrl[ecm_pkg::CTRL_WREN];
  wire rdTick = rdClkS2 && !rdClkS3 && ctrl[ecm_pkg::CTRL_RDEN];
  wire wrSideClr = wrClrS2 || globalClr;
  wire rdSideClr = rdClrS2 || globalClr;

  // write side: registered request and search-write sequencer
  ecm_pkg::ecm_cw_state_type cwState, next_cwState;
  logic ramWrGo;
  wire camStart = wrTick && camMode && wrReqS2.strobe;
  wire ramCapture = wrTick && !camMode;
  // an early release shows up as a dropped strobe or a new address at the next tick
  wire heldSame = wrReqS2.strobe && wrReqS2.addr == wrQ.addr;

  // the sequence aborts if user logic lets go of the write early
  always_comb begin
    next_cwState = cwState;
    case (cwState)
      // first tick with strobe captures the request
      ecm_pkg::CW_IDLE: begin
        if (camStart) begin
          next_cwState = ecm_pkg::CW_DATA;
        end
      end
      // second tick writes the word; a third follows only for a held mask
      ecm_pkg::CW_DATA: begin
        if (wrTick) begin
          next_cwState = (heldSame && wrQ.maskEn) ? ecm_pkg::CW_MASK : ecm_pkg::CW_IDLE;
        end
      end
      // third tick writes the compare mask
      ecm_pkg::CW_MASK: begin
        if (wrTick) begin
          next_cwState = ecm_pkg::CW_IDLE;
        end
      end
      default: begin
        next_cwState = ecm_pkg::CW_IDLE;
      end
    endcase
  end

  wire camDataWr = cwState == ecm_pkg::CW_DATA && wrTick && heldSame;
  wire camMaskWr = cwState == ecm_pkg::CW_MASK && wrTick && heldSame;

  // write-side registers; clears act here, after the synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrQ <= '0;
      cwState <= ecm_pkg::CW_IDLE;
      ramWrGo <= 1'b0;
      writeBusy <= 1'b0;
    end else if (wrSideClr) begin
      wrQ <= '0;
      cwState <= ecm_pkg::CW_IDLE;
      ramWrGo <= 1'b0;
      writeBusy <= 1'b0;
    end else begin
      if (ramCapture || (camStart && cwState == ecm_pkg::CW_IDLE)) begin
        wrQ <= wrReqS2;
      end
      ramWrGo <= ramCapture && wrReqS2.strobe;
      cwState <= next_cwState;
      writeBusy <= next_cwState != ecm_pkg::CW_IDLE;
    end
  end

  // storage: words and per-bit compare enables (1 = bit is compared)
  // ram and search writes never meet: the mode bit picks one path per tick
  logic [ecm_pkg::WIDTH-1:0] mem [ecm_pkg::DEPTH];
  logic [ecm_pkg::WIDTH-1:0] care [ecm_pkg::DEPTH];

  // reset stands in for configuration preload; later writes overwrite it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ecm_pkg::DEPTH; i++) begin
        mem[i] <= ecm_pkg::ecm_init_word(i);
        care[i] <= '1;
      end
    end else begin
      if (ramWrGo && wrQ.strobe) begin
        mem[wrQ.addr] <= wrQ.data;
      end
      if (camDataWr) begin
        mem[wrQ.addr] <= wrQ.data;
        care[wrQ.addr] <= '1;
      end
      if (camMaskWr) begin
        care[wrQ.addr] <= ~wrQ.mask;
      end
    end
  end

  // compare key against all entries in parallel
  // a word being written still shows its old value to a search in the same cycle
  logic [ecm_pkg::DEPTH-1:0] hitVec;
  always_comb begin
    for (int i = 0; i < ecm_pkg::DEPTH; i++) begin
      hitVec[i] = ((mem[i] ^ rdReqS2.key) & care[i]) == '0;
    end
  end

  wire searchGo = rdTick && camMode && rdReqS2.strobe;
  wire ramRead = rdTick && !camMode && rdReqS2.strobe;

  // read side: data and search results, advanced only at read ticks
  // the upper half waits for the next read tick, so a slow read clock holds it
  logic [ecm_pkg::DEPTH-1:0] matchVec;
  logic upperPending;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= '0;
      matchVec <= '0;
      matchFound <= 1'b0;
      matchAddr <= '0;
      matchLines <= '0;
      matchUpper <= 1'b0;
      upperPending <= 1'b0;
    end else if (rdSideClr) begin
      rdData <= '0;
      matchVec <= '0;
      matchFound <= 1'b0;
      matchAddr <= '0;
      matchLines <= '0;
      matchUpper <= 1'b0;
      upperPending <= 1'b0;
    end else if (rdTick) begin
      if (ramRead) begin
        rdData <= mem[rdReqS2.addr];
      end
      if (searchGo) begin
        matchVec <= hitVec;
        matchFound <= |hitVec;
        matchAddr <= firstMatch(hitVec);
        matchLines <= encMode ? '0 : hitVec[ecm_pkg::HALF-1:0];
        matchUpper <= 1'b0;
        upperPending <= !encMode;
        if (encMode) begin
          rdData <= {27'h0000000, firstMatch(hitVec)};
        end else begin
          rdData <= 32'(hitVec[ecm_pkg::HALF-1:0]);
        end
      end else if (upperPending) begin
        // second cycle of an unencoded result shows entries 16 to 31
        matchLines <= matchVec[ecm_pkg::DEPTH-1:ecm_pkg::HALF];
        matchUpper <= 1'b1;
        upperPending <= 1'b0;
        rdData <= 32'(matchVec[31:16]);
      end
    end
  end

  // apb answer one cycle into the access phase; unmapped reads zero with error
  // answer registers are kept apart from ctrl so a read never disturbs it
  wire logic [31:0] statusWord;
  logic [31:0] readMux;
  // status bits by field position
  assign statusWord[ecm_pkg::ST_FOUND] = matchFound;
  assign statusWord[ecm_pkg::ST_BUSY] = writeBusy;
  assign statusWord[ecm_pkg::ST_UPPER] = matchUpper;
  assign statusWord[ecm_pkg::ST_PHASE] = upperPending;
  assign statusWord[31:4] = 28'h0000000;
  assign readMux = selCtrl ? 32'(ctrl) : selStatus ? statusWord : selMatch ? matchVec : 32'h0;

  // pready, prdata and pslverr stand for one cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !apbHit;
      prdata <= (apbAccess && !pwrite) ? readMux : 32'h00000000;
    end
  end

  // control register and its self-clearing global clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= ecm_pkg::CTRL_RESET;
      globalClr <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        ctrl <= pwdata[ecm_pkg::CTRL_BITS-1:0];
      end
      // one core cycle wide, never stored
      globalClr <= ctrlWrite && pwdata[ecm_pkg::CTRL_GCLR];
    end
  end

endmodule : ecm_memory_block
`default_nettype wire

// ==== design/ecm_pkg.sv ====
// ecm_pkg: constants, types and helpers of the embedded memory block with search mode
// assumes: one core clock; all user-side pins come from other clock domains
package ecm_pkg;
  localparam int DEPTH = 32;
  localparam int WIDTH = 32;
  localparam int AW = 5;
  localparam int HALF = 16;
  // apb register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MATCH = 12'h008;
  // control field positions
  localparam int CTRL_CAM = 0;
  localparam int CTRL_ENC = 1;
  localparam int CTRL_WREN = 2;
  localparam int CTRL_RDEN = 3;
  localparam int CTRL_GCLR = 4;
  localparam int CTRL_BITS = 4;
  localparam logic [3:0] CTRL_RESET = 4'hC;
  // status field positions
  localparam int ST_FOUND = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_UPPER = 2;
  localparam int ST_PHASE = 3;
  // search memory write sequence
  typedef enum logic [1:0] {
    CW_IDLE = 2'b00,
    CW_DATA = 2'b01,
    CW_MASK = 2'b10
  } ecm_cw_state_type;
  // write-side request bundle
  typedef struct packed {
    logic strobe;
    logic [AW-1:0] addr;
    logic [WIDTH-1:0] data;
    logic [WIDTH-1:0] mask;
    logic maskEn;
  } ecm_wr_req_type;
  // read-side request bundle
  typedef struct packed {
    logic strobe;
    logic [AW-1:0] addr;
    logic [WIDTH-1:0] key;
  } ecm_rd_req_type;
  // contents loaded at configuration: each word holds its own index
  function automatic logic [WIDTH-1:0] ecm_init_word(input int idx);
    ecm_init_word = WIDTH'(idx);
  endfunction : ecm_init_word
endpackage : ecm_pkg

// ==== verification/ecm_memory_block_properties.sv ====
// ecm_memory_block_properties: port-level checks of the memory block
// assumes: user pins paced by ecm_user_side, five core cycles per pin phase
`timescale 1ns/100ps
`default_nettype none
module ecm_memory_block_properties (
  // clock and chip reset
  input wire logic core_clk,
  input wire logic arst_n,
  // user pins and results
  input wire logic wrClk,
  input wire logic wrClr,
  input wire logic rdClk,
  input wire logic rdClr,
  input wire logic matchFound,
  input wire logic [15:0] matchLines,
  input wire logic matchUpper,
  input wire logic writeBusy
);
  // one domain, so clock and reset are stated once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_write_tick: assert property ($rose(writeBusy) |-> $past(wrClk, 2))
    else $error("write began without a write clock edge");
  a_read_tick: assert property ($rose(matchUpper) |-> $past(rdClk, 2))
    else $error("upper half shown without a read clock edge");
  a_busy_span: assert property ($rose(writeBusy) |=> writeBusy [*3])
    else $error("write busy dropped before the next tick");
  a_busy_ends: assert property ($rose(writeBusy) |-> ##[1:40] !writeBusy)
    else $error("write busy never ended");
  a_wr_clear: assert property (wrClr [*5] |=> !writeBusy)
    else $error("write clear left busy set");
  a_rd_clear: assert property (rdClr [*5] |=> !matchFound && !matchUpper)
    else $error("read clear left a search result");
  a_none_quiet: assert property (!matchFound |-> matchLines == 16'h0000)
    else $error("match lines set with no match");
  // reset itself is checked, so this one is never disabled
  a_reset_zero: assert property (disable iff (1'b0) !arst_n |-> !writeBusy && !matchFound)
    else $error("outputs not cleared in reset");
endmodule : ecm_memory_block_properties
bind ecm_memory_block ecm_memory_block_properties u_ecm_memory_block_properties (.core_clk,
  .arst_n, .wrClk, .wrClr, .rdClk, .rdClr, .matchFound, .matchLines, .matchUpper, .writeBusy);
`default_nettype wire

// ==== verification/ecm_user_side.sv ====
// ecm_user_side: fabric logic that paces the clock pins and feeds requests
// assumes: tasks are called by the bench; core_clk comes from the bench
`timescale 1ns/100ps
`default_nettype none
module ecm_user_side (
  // pacing clock
  input wire logic core_clk,
  // write side
  output logic wrClk,
  output logic wrStrobe,
  output logic [4:0] wrAddr,
  output logic [31:0] wrData,
  output logic [31:0] wrMask,
  output logic wrMaskEn,
  // read side
  output logic rdClk,
  output logic read_strobe,
  output logic [4:0] rdAddr,
  output logic [31:0] searchKey
);
  // pins start low; the clock pins stay still between requests
  initial {wrClk, wrStrobe, wrAddr, wrData, wrMask, wrMaskEn,
    rdClk, read_strobe, rdAddr, searchKey} = '0;
  // one pin clock cycle, long phases so the sampled edge is clean
  task automatic tick(input logic wr);
    @(posedge core_clk);
    if (wr) wrClk <= 1'b1;
    else rdClk <= 1'b1;
    repeat (5) @(posedge core_clk);
    wrClk <= 1'b0;
    rdClk <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask : tick
  // entry write: request held over two ticks, three with don't-care bits
  task automatic write(input logic [4:0] a, input logic [31:0] d, m, input logic me);
    @(posedge core_clk);
    wrStrobe <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    wrMask <= m;
    wrMaskEn <= me;
    repeat (me ? 3 : 2) tick(1'b1);
    wrStrobe <= 1'b0;
    wrData <= ~d; // released lines do not keep the old word
    wrMask <= ~m;
  endtask : write
  // one read or search, taken at a single read tick
  task automatic search(input logic [4:0] a, input logic [31:0] k);
    @(posedge core_clk);
    read_strobe <= 1'b1;
    rdAddr <= a;
    searchKey <= k;
    tick(1'b0);
    read_strobe <= 1'b0;
    searchKey <= ~k;
  endtask : search
endmodule : ecm_user_side
`default_nettype wire

// ==== verification/tb.sv ====
// tb: self-checking bench with apb master, result model and user-side partner
// assumes: apb answers within the access phase; pins paced by ecm_user_side
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic wrClr = 1'b0;
  logic rdClr = 1'b0;
  logic [31:0] prdata, wrData, wrMask, searchKey, rdData;
  logic [4:0] wrAddr, rdAddr, matchAddr;
  logic [15:0] matchLines;
  logic pready, pslverr, wrClk, wrStrobe, wrMaskEn, rdClk, read_strobe;
  logic matchFound, matchUpper, writeBusy;
  logic [31:0] mem [32];
  logic [31:0] care [32];
  logic [15:0] lfsr = 16'hDA44;
  int num_errors = 0;
  int cmp_count = 0;
  always #2 core_clk = ~core_clk;
  ecm_memory_block u_ecm_memory_block (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wrClk, .wrClr, .wrStrobe, .wrAddr, .wrData, .wrMask,
    .wrMaskEn, .rdClk, .rdClr, .read_strobe, .rdAddr, .searchKey, .rdData, .matchFound,
    .matchAddr, .matchLines, .matchUpper, .writeBusy);
  ecm_user_side u_ecm_user_side (.core_clk, .wrClk, .wrStrobe, .wrAddr, .wrData, .wrMask,
    .wrMaskEn, .rdClk, .read_strobe, .rdAddr, .searchKey);
  // fixed-seed lfsr for data and keys
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rnd = {lfsr, lfsr ^ 16'hA5C3};
  endfunction : rnd
  // model: an entry hits when every cared-for bit equals the key
  function automatic logic [31:0] hits(input logic [31:0] k);
    for (int i = 0; i < 32; i++) hits[i] = ((mem[i] ^ k) & care[i]) == 32'h00000000;
  endfunction : hits
  task automatic check(input string n, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  // apb transfer; pready is read before that edge's updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one search compared against the model, both halves when unencoded
  task automatic search_check(input logic [31:0] k, input logic enc);
    logic [31:0] v;
    logic [31:0] r;
    logic e;
    int lo;
    v = hits(k);
    lo = 0;
    while (lo < 31 && !v[lo]) lo++;
    u_ecm_user_side.search(5'h00, k);
    check("found", 32'(matchFound), 32'(v != 0));
    if (v != 0) check("index", enc ? rdData : 32'(matchAddr), 32'(lo));
    apb(1'b0, ecm_pkg::OFS_MATCH, 32'h0, r, e);
    check("vector", r, v);
    if (!enc) begin
      check("lower", 32'(matchLines), 32'(v[15:0]));
      u_ecm_user_side.tick(1'b0);
      check("upper", {15'h0000, matchUpper, matchLines}, {16'h0001, v[31:16]});
    end
  endtask : search_check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    logic [31:0] r, d1, m;
    logic e;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 32'(i);
      care[i] = 32'hFFFFFFFF;
    end
    #1 arst_n = 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, ecm_pkg::OFS_CTRL, 32'h0, r, e);
    check("ctrl", r, 32'(ecm_pkg::CTRL_RESET));
    apb(1'b0, 12'h00C, 32'h0, r, e);
    check("unmapped", {r[30:0], e}, 32'h00000001);
    $display("registers test done");
    for (int i = 0; i < 32; i += 13) begin
      u_ecm_user_side.search(5'(i), rnd());
      check("ram word", rdData, mem[i]);
    end
    $display("preload test done");
    apb(1'b1, ecm_pkg::OFS_CTRL, 32'h0000000D, r, e);
    d1 = rnd();
    m = rnd();
    u_ecm_user_side.write(5'h03, d1, m, 1'b1);
    u_ecm_user_side.write(5'h14, d1, m, 1'b0);
    mem[3] = d1;
    care[3] = ~m;
    mem[20] = d1;
    search_check(d1, 1'b0);
    search_check(d1 ^ m, 1'b0);
    search_check(rnd(), 1'b0);
    $display("unencoded test done");
    apb(1'b1, ecm_pkg::OFS_CTRL, 32'h0000000F, r, e);
    search_check(d1 ^ m, 1'b1);
    search_check(32'h00000009, 1'b1);
    // a write-side clear must leave the search result alone
    wrClr <= 1'b1;
    repeat (8) @(posedge core_clk);
    wrClr <= 1'b0;
    check("kept", 32'(matchFound), 32'h1);
    rdClr <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdClr <= 1'b0;
    check("cleared", 32'(matchFound), 32'h0);
    $display("encoded and clear test done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
